/* logic/aipd_pkg.sv */
// constants, record maps and carrier types of the analog input parameter and diagnostic record bank
// Functional notes
// RULE_01 - Two-byte suppression parameter at record 01h, resets to 0000h.
// RULE_02 - One function byte per channel at records 80h..87h, reset 31h.
// RULE_03 - Two suppression bits per channel: 00 off, 01 60 Hz, 10 50 Hz.
// RULE_04 - Function byte FFh switches that channel's measurement off.
// RULE_05 - Only 30h, 31h, 40h, 41h and FFh are valid function bytes.
// RULE_06 - 31h/30h scale full range to 27648, limits 32511 and -4864, origin 0/4 mA.
// RULE_07 - 41h/40h scale full range to 16384, limits 20480 and -3277, origin 0/4 mA.
// RULE_08 - No interrupt; errors light the channel indicator and enter the diagnostic record.
// RULE_09 - Detect parameter errors, range overflow and range underflow.
// RULE_10 - The whole diagnostic record reads as record 01h.
// RULE_11 - Record 00h returns only the first four diagnostic bytes.
// RULE_12 - Index 2F01h gives the full diagnostics, 2F00h the first four bytes.
// RULE_13 - Diagnostic entries at object 5005h, subindices 02h..13h in record order.
// RULE_14 - Parameters at subindices 01h..09h, and at indices 3100h..3109h.
// RULE_15 - Diagnostic bits per channel byte reads constant 08h.
// RULE_16 - Channel count 08h, channel kind 71h, module information 15h.
// RULE_17 - One error byte per channel, subindices 0Ah..11h, cleared at reset.
// RULE_18 - 32-bit microsecond ticker from zero, wraps; captured on a diagnostic event.
// RULE_19 - Summary byte bit n set while channel n has any error.
// RULE_20 - Error byte: bit 0 parameter error, bit 6 underflow, bit 7 overflow.
// RULE_21 - General byte: bits 0..4 failure/internal/external/channel/supply, bit 7 parameter.
// RULE_22 - Unsupported function byte counts as a parameter error of that channel.
package aipd_pkg;
  localparam int NUM_CH = 8;
  // access paths on the record port
  localparam logic [1:0] PATH_REC   = 2'h0;
  localparam logic [1:0] PATH_IDX   = 2'h1;
  localparam logic [1:0] PATH_SUBP  = 2'h2;
  localparam logic [1:0] PATH_SUBD  = 2'h3;
  // record numbers, indices and subindices
  localparam logic [15:0] REC_DIAG4  = 16'h0000;
  localparam logic [15:0] REC_ONE    = 16'h0001;
  localparam logic [15:0] REC_FN0    = 16'h0080;
  localparam logic [15:0] IDX_FLT0   = 16'h3100;
  localparam logic [15:0] IDX_FLT1   = 16'h3101;
  localparam logic [15:0] IDX_FN0    = 16'h3102;
  localparam logic [15:0] IDX_DIAG4  = 16'h2F00;
  localparam logic [15:0] IDX_DIAG   = 16'h2F01;
  localparam logic [15:0] SUB_FLT    = 16'h0001;
  localparam logic [15:0] SUB_FN0    = 16'h0002;
  localparam logic [15:0] SUB_DFIRST = 16'h0002;
  localparam logic [15:0] SUB_DLAST1 = 16'h0011;
  localparam logic [15:0] SUB_STAMP  = 16'h0013;
  localparam logic [4:0]  DIAG_LEN   = 5'h14;
  localparam logic [4:0]  DIAG4_LEN  = 5'h04;
  localparam logic [4:0]  STAMP_POS  = 5'h10;
  // reset values and constant bytes
  localparam logic [15:0] FLT_RST    = 16'h0000;
  localparam logic [7:0]  FN_RST     = 8'h31;
  localparam logic [7:0]  MODINFO    = 8'h15;
  localparam logic [7:0]  CHKIND     = 8'h71;
  localparam logic [7:0]  DIAGBITS   = 8'h08;
  localparam logic [7:0]  CHCOUNT    = 8'h08;
  // function numbers
  localparam logic [7:0]  FN_WIDE_4MA = 8'h30;
  localparam logic [7:0]  FN_WIDE_0MA = 8'h31;
  localparam logic [7:0]  FN_NARR_4MA = 8'h40;
  localparam logic [7:0]  FN_NARR_0MA = 8'h41;
  localparam logic [7:0]  FN_OFF     = 8'hFF;
  localparam logic [1:0]  SUP_BAD    = 2'h3;
  // scaling: current arrives in microamps
  localparam int FULL_WIDE = 27648;
  localparam int OVR_WIDE  = 32511;
  localparam int UND_WIDE  = -4864;
  localparam int FULL_NARR = 16384;
  localparam int OVR_NARR  = 20480;
  localparam int UND_NARR  = -3277;
  localparam int SPAN_0MA = 20000;
  localparam int SPAN_4MA = 16000;
  localparam int ORG_4MA  = 4000;
  // error byte and general byte fields
  localparam int EB_PARAM = 0;
  localparam int EB_UNDER = 6;
  localparam int EB_OVER  = 7;
  localparam int GA_FAIL  = 0;
  localparam int GA_INT   = 1;
  localparam int GA_EXT   = 2;
  localparam int GA_CHAN  = 3;
  localparam int GA_AUX   = 4;
  localparam int GA_PARM  = 7;
  localparam int GD_COMM  = 4;
  // microsecond ticker
  localparam int TICK_NS  = 1000;
  localparam int CLK_NS   = 50;
  localparam logic [4:0] TICK_CYC = 5'(TICK_NS / CLK_NS);

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  path;
    logic [15:0] sel;
    logic [4:0]  byte_ix;
    logic [7:0]  wdata;
  } aipd_req_t;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] rdata;
  } aipd_rsp_t;

  typedef struct packed {
    logic               valid;
    logic [2:0]         ch;
    logic signed [15:0] cur_ua;
  } aipd_smp_t;

  typedef struct packed {
    logic               valid;
    logic [2:0]         ch;
    logic signed [15:0] value;
  } aipd_meas_t;

  function automatic logic aipd_fn_ok(input logic [7:0] fn);
    return fn == FN_WIDE_4MA || fn == FN_WIDE_0MA || fn == FN_NARR_4MA || fn == FN_NARR_0MA || fn == FN_OFF;
  endfunction
endpackage

/* logic/aipd_top.sv */
// parameter and diagnostic record bank with current scaling for eight input channels
`timescale 1ns/1ps
module aipd_top
  import aipd_pkg::*;
(
  // clock, reset, enable
  input  wire logic       CORE_CLK,
  input  wire logic       RESETN,
  input  wire logic       CLK_EN,
  // record access port
  input  wire aipd_req_t  REQ,
  output aipd_rsp_t       RSP,
  // converter samples and scaled results
  input  wire aipd_smp_t  SAMPLE,
  output aipd_meas_t      MEAS,
  // supply and communication status pins
  input  wire logic       AUX_MISSING,
  input  wire logic       INT_COMM_ERR,
  // front-end control and indicators
  output logic [15:0]     FILTER_SEL,
  output logic [7:0]      CH_ACTIVE,
  output logic [7:0]      CH_ERR_LED,
  output logic            MOD_ERR_LED
);

  // parameter state
  logic [15:0] flt_q, flt_d;
  logic [7:0]  fn_q [NUM_CH];
  logic [7:0]  fn_d [NUM_CH];
  // diagnostic state
  logic [1:0]  rng_q [NUM_CH];
  logic [1:0]  rng_d [NUM_CH];
  logic [7:0]  err_q [NUM_CH];
  logic [7:0]  err_d [NUM_CH];
  logic [7:0]  sum_q, sum_d;
  logic [7:0]  gen_q, gen_d;
  logic [7:0]  gend_q, gend_d;
  logic [31:0] us_q, us_d;
  logic [4:0]  div_q, div_d;
  logic [31:0] stamp_q, stamp_d;
  // synchronisers for the two status pins
  logic [1:0]  aux_s, comm_s;
  // port registers
  aipd_rsp_t   rsp_d;
  aipd_meas_t  meas_d;
  logic [7:0]  act_d;
  // helpers
  logic [7:0]  diag [20];
  logic [7:0]  perr;
  logic [7:0]  new_err;

  // pins come from outside, two flops before use
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      aux_s  <= 2'h0;
      comm_s <= 2'h0;
    end else if (CLK_EN) begin
      aux_s  <= {aux_s[0], AUX_MISSING};
      comm_s <= {comm_s[0], INT_COMM_ERR};
    end
  end

  // parameter error per channel: bad function byte or reserved filter code
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      perr[c] = !aipd_fn_ok(fn_q[c]) || flt_q[2*c +: 2] == SUP_BAD;  // see RULE_05, see RULE_22
    end
  end

  // diagnostic record image, bytes in record order
  always_comb begin
    diag[0] = gen_q;
    diag[1] = MODINFO;   // see RULE_16
    diag[2] = 8'h00;
    diag[3] = gend_q;
    diag[4] = CHKIND;    // see RULE_16
    diag[5] = DIAGBITS;  // see RULE_15
    diag[6] = CHCOUNT;   // see RULE_16
    diag[7] = sum_q;
    for (int c = 0; c < NUM_CH; c++) begin
      diag[8 + c] = err_q[c];
    end
    for (int b = 0; b < 4; b++) begin
      diag[16 + b] = stamp_q[8*b +: 8];  // low byte first
    end
  end

  // record port decode: writes reach parameters, reads of 01h give diagnostics
  always_comb begin
    flt_d = flt_q;
    for (int c = 0; c < NUM_CH; c++) begin
      fn_d[c] = fn_q[c];
    end
    rsp_d = '0;
    if (REQ.valid) begin
      rsp_d.valid = 1'b1;
      rsp_d.err   = 1'b1;
      case (REQ.path)
        PATH_REC: begin
          if (!REQ.write && REQ.sel == REC_ONE && REQ.byte_ix < DIAG_LEN) begin
            rsp_d.err   = 1'b0;  // see RULE_10
            rsp_d.rdata = diag[REQ.byte_ix];
          end else if (!REQ.write && REQ.sel == REC_DIAG4 && REQ.byte_ix < DIAG4_LEN) begin
            rsp_d.err   = 1'b0;  // see RULE_11
            rsp_d.rdata = diag[REQ.byte_ix];
          end else if (REQ.write && REQ.sel == REC_ONE && REQ.byte_ix < 5'h02) begin
            rsp_d.err = 1'b0;
            flt_d[8*REQ.byte_ix[0] +: 8] = REQ.wdata;  // see RULE_01, see RULE_03
          end else if (REQ.sel[15:3] == REC_FN0[15:3] && REQ.byte_ix == 5'h00) begin
            rsp_d.err = 1'b0;
            rsp_d.rdata = fn_q[REQ.sel[2:0]];
            if (REQ.write) begin
              fn_d[REQ.sel[2:0]] = REQ.wdata;  // see RULE_02
            end
          end
        end
        PATH_IDX: begin
          if (REQ.sel == IDX_DIAG && !REQ.write && REQ.byte_ix < DIAG_LEN) begin
            rsp_d.err   = 1'b0;  // see RULE_12
            rsp_d.rdata = diag[REQ.byte_ix];
          end else if (REQ.sel == IDX_DIAG4 && !REQ.write && REQ.byte_ix < DIAG4_LEN) begin
            rsp_d.err   = 1'b0;  // see RULE_12
            rsp_d.rdata = diag[REQ.byte_ix];
          end else if ((REQ.sel == IDX_FLT0 || REQ.sel == IDX_FLT1) && REQ.byte_ix == 5'h00) begin
            rsp_d.err   = 1'b0;  // see RULE_14
            rsp_d.rdata = flt_q[8*REQ.sel[0] +: 8];
            if (REQ.write) begin
              flt_d[8*REQ.sel[0] +: 8] = REQ.wdata;
            end
          end else if (REQ.sel >= IDX_FN0 && REQ.sel < IDX_FN0 + 16'h0008 && REQ.byte_ix == 5'h00) begin
            rsp_d.err   = 1'b0;  // see RULE_14
            rsp_d.rdata = fn_q[3'(REQ.sel - IDX_FN0)];
            if (REQ.write) begin
              fn_d[3'(REQ.sel - IDX_FN0)] = REQ.wdata;
            end
          end
        end
        PATH_SUBP: begin
          if (REQ.sel == SUB_FLT && REQ.byte_ix < 5'h02) begin
            rsp_d.err   = 1'b0;  // see RULE_14
            rsp_d.rdata = flt_q[8*REQ.byte_ix[0] +: 8];
            if (REQ.write) begin
              flt_d[8*REQ.byte_ix[0] +: 8] = REQ.wdata;
            end
          end else if (REQ.sel >= SUB_FN0 && REQ.sel < SUB_FN0 + 16'h0008 && REQ.byte_ix == 5'h00) begin
            rsp_d.err   = 1'b0;
            rsp_d.rdata = fn_q[3'(REQ.sel - SUB_FN0)];
            if (REQ.write) begin
              fn_d[3'(REQ.sel - SUB_FN0)] = REQ.wdata;
            end
          end
        end
        PATH_SUBD: begin
          // subindex 12h is a gap in the object, answered as unmapped
          if (!REQ.write && REQ.sel >= SUB_DFIRST && REQ.sel <= SUB_DLAST1 && REQ.byte_ix == 5'h00) begin
            rsp_d.err   = 1'b0;  // see RULE_13, see RULE_17
            rsp_d.rdata = diag[5'(REQ.sel - SUB_DFIRST)];
          end else if (!REQ.write && REQ.sel == SUB_STAMP && REQ.byte_ix < 5'h04) begin
            rsp_d.err   = 1'b0;  // see RULE_13
            rsp_d.rdata = diag[STAMP_POS + REQ.byte_ix];
          end
        end
        default: rsp_d.err = 1'b1;
      endcase
    end
  end

  // scaling of one sample; division by a constant span keeps the exact figures
  always_comb begin
    logic signed [31:0] diff;
    logic signed [31:0] full;
    logic signed [31:0] span;
    logic signed [31:0] ovr;
    logic signed [31:0] und;
    logic signed [31:0] raw;
    logic [7:0]         fn;
    diff = 32'(SAMPLE.cur_ua);
    fn = fn_q[SAMPLE.ch];
    full = FULL_WIDE;
    span = SPAN_0MA;
    ovr = OVR_WIDE;
    und = UND_WIDE;
    if (fn == FN_NARR_0MA || fn == FN_NARR_4MA) begin
      full = FULL_NARR;  // see RULE_07
      ovr  = OVR_NARR;
      und  = UND_NARR;
    end
    if (fn == FN_WIDE_4MA || fn == FN_NARR_4MA) begin
      diff = diff - ORG_4MA;  // 4 mA origin, see RULE_06, see RULE_07
      span = SPAN_4MA;
    end
    raw = (diff * full) / span;  // see RULE_06
    for (int c = 0; c < NUM_CH; c++) begin
      rng_d[c] = rng_q[c];
    end
    meas_d = '0;
    // an off or unsupported channel drops its samples and holds no range error
    if (SAMPLE.valid && fn != FN_OFF && aipd_fn_ok(fn)) begin  // see RULE_04
      meas_d.valid = 1'b1;
      meas_d.ch    = SAMPLE.ch;
      rng_d[SAMPLE.ch] = {raw > ovr, raw < und};  // see RULE_09
      if (raw > ovr) begin
        meas_d.value = 16'(ovr);
      end else if (raw < und) begin
        meas_d.value = 16'(und);
      end else begin
        meas_d.value = 16'(raw);
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (fn_q[c] == FN_OFF || !aipd_fn_ok(fn_q[c])) begin
        rng_d[c] = 2'h0;
      end
    end
  end

  // error bytes, summary and general flags follow the live conditions
  always_comb begin
    sum_d = '0;
    new_err = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      err_d[c] = '0;
      err_d[c][EB_PARAM] = perr[c];      // see RULE_20
      err_d[c][EB_UNDER] = rng_d[c][0];  // see RULE_20
      err_d[c][EB_OVER]  = rng_d[c][1];  // see RULE_20
      sum_d[c] = |err_d[c];              // see RULE_19
      new_err[c] = |(err_d[c] & ~err_q[c]);
    end
    gen_d = '0;
    gen_d[GA_INT]  = comm_s[1];
    gen_d[GA_EXT]  = |(sum_d & ~perr);
    gen_d[GA_CHAN] = |sum_d;
    gen_d[GA_AUX]  = aux_s[1];
    gen_d[GA_PARM] = |perr;
    gen_d[GA_FAIL] = |gen_d;  // see RULE_21
    gend_d = '0;
    gend_d[GD_COMM] = comm_s[1];
    for (int c = 0; c < NUM_CH; c++) begin
      act_d[c] = fn_d[c] != FN_OFF;  // see RULE_04
    end
  end

  // microsecond ticker and capture on each newly raised error bit
  always_comb begin
    div_d = div_q + 5'h01;
    us_d = us_q;
    if (div_q == TICK_CYC - 5'h01) begin
      div_d = 5'h00;
      us_d = us_q + 32'h00000001;  // wraps to zero by width, see RULE_18
    end
    stamp_d = stamp_q;
    if (|new_err || (gen_d & ~gen_q) != 8'h00) begin
      stamp_d = us_q;  // see RULE_18
    end
  end

  // state registers; everything holds while the clock enable is low
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      flt_q       <= FLT_RST;
      sum_q       <= 8'h00;
      gen_q       <= 8'h00;
      gend_q      <= 8'h00;
      us_q        <= 32'h00000000;
      div_q       <= 5'h00;
      stamp_q     <= 32'h00000000;
      RSP         <= '0;
      MEAS        <= '0;
      FILTER_SEL  <= FLT_RST;
      CH_ACTIVE   <= 8'hFF;
      CH_ERR_LED  <= 8'h00;
      MOD_ERR_LED <= 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
        fn_q[c]  <= FN_RST;  // see RULE_02
        rng_q[c] <= 2'h0;
        err_q[c] <= 8'h00;   // see RULE_17
      end
    end else if (CLK_EN) begin
      flt_q       <= flt_d;
      sum_q       <= sum_d;
      gen_q       <= gen_d;
      gend_q      <= gend_d;
      us_q        <= us_d;
      div_q       <= div_d;
      stamp_q     <= stamp_d;
      RSP         <= rsp_d;
      MEAS        <= meas_d;
      FILTER_SEL  <= flt_d;    // see RULE_03
      CH_ACTIVE   <= act_d;
      CH_ERR_LED  <= sum_d;    // see RULE_08
      MOD_ERR_LED <= gen_d[GA_FAIL];
      for (int c = 0; c < NUM_CH; c++) begin
        fn_q[c]  <= fn_d[c];
        rng_q[c] <= rng_d[c];
        err_q[c] <= err_d[c];
      end
    end
  end

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  rsp_one_cycle_a: assert property (REQ.valid && CLK_EN |=> RSP.valid)  // see RULE_10
    else $error("request not answered in one cycle");
  diag_consts_a: assert property (REQ.valid && CLK_EN && !REQ.write && REQ.path == PATH_REC && REQ.sel == REC_ONE
    && REQ.byte_ix == 5'h04 |=> RSP.rdata == 8'h71 && !RSP.err)  // see RULE_16
    else $error("channel kind byte wrong");
  diag_short_a: assert property (REQ.valid && CLK_EN && !REQ.write && REQ.path == PATH_REC && REQ.sel == REC_DIAG4
    && REQ.byte_ix == 5'h04 |=> RSP.err)  // see RULE_11
    else $error("short record returned byte four");
  fn_off_a: assert property (REQ.valid && CLK_EN && REQ.write && REQ.path == PATH_REC && REQ.sel == 16'h0080
    && REQ.byte_ix == 5'h00 && REQ.wdata == 8'hFF |=> !CH_ACTIVE[0])  // see RULE_04
    else $error("channel not switched off");
  bad_fn_led_a: assert property (REQ.valid && CLK_EN && REQ.write && REQ.path == PATH_IDX && REQ.sel == 16'h3103
    && REQ.byte_ix == 5'h00 && REQ.wdata == 8'h55 ##1 CLK_EN |=> CH_ERR_LED[1])  // see RULE_22
    else $error("bad function byte not flagged");
  meas_limit_a: assert property (MEAS.valid |-> MEAS.value <= 16'sd32511 && MEAS.value >= -16'sd4864)  // see RULE_06
    else $error("scaled value outside limits");
  over_flag_a: assert property (CLK_EN && SAMPLE.valid && SAMPLE.ch == 3'h1 && fn_q[1] == 8'h31
    && SAMPLE.cur_ua > 16'sd23600 |=> err_q[1][7] && CH_ERR_LED[1])  // see RULE_09
    else $error("overflow not recorded");
  tick_div_a: assert property (CLK_EN && div_q == 5'd19 |=> us_q == $past(us_q) + 32'h1)  // see RULE_18
    else $error("ticker step wrong");
  freeze_a: assert property (!CLK_EN |=> $stable(us_q) && $stable(RSP))  // see RULE_18
    else $error("state moved with enable low");
  param_bit_a: assert property (CLK_EN && fn_q[1] == 8'h55 |=> err_q[1][0] && gen_q[7])  // see RULE_20
    else $error("parameter error bit missing");

  cov_full_read_c: cover property (REQ.valid && REQ.path == PATH_SUBD && REQ.sel == SUB_STAMP ##1 !RSP.err);
  cov_overflow_c: cover property (MEAS.valid && MEAS.value == 16'sd32511);
  cov_underflow_c: cover property (MEAS.valid && MEAS.value == -16'sd3277);
  cov_fn_off_c: cover property (CH_ACTIVE != 8'hFF);

endmodule

/* tb/aipd_host.sv */
// bus coupler model: issues record accesses and collects the answers
`timescale 1ns/1ps
module aipd_host
  import aipd_pkg::*;
(
  // clock
  input  wire logic      clk,
  // record port
  output aipd_req_t      req,
  input  wire aipd_rsp_t rsp
);
  initial req = '0;

  // one access, held up to the taking edge; answer read within four cycles
  task automatic xfer(input logic wr, input logic [1:0] path, input logic [15:0] sel, input logic [4:0] bix,
                      input logic [7:0] wd, output logic [7:0] rd, output logic er);
    int n;
    n = 0;
    req = {1'b1, wr, path, sel, bix, wd};
    @(posedge clk);
    // released fields are scrambled so a stale value cannot pass for a held one
    #2 req = {1'b0, ~wr, ~path, ~sel, ~bix, ~wd};
    while (rsp.valid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #2 n++;
    end
    rd = rsp.rdata;
    er = (rsp.valid === 1'b1) ? rsp.err : 1'bx;
    // one idle edge so the next request never lands in this time step
    @(posedge clk);
    #2;
  endtask
endmodule

/* tb/analog_input_param_diag_records_tb.sv */
// self-checking bench for the parameter and diagnostic record bank
`timescale 1ns/1ps
module analog_input_param_diag_records_tb
  import aipd_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        en;
  aipd_req_t   req;
  aipd_rsp_t   rsp;
  aipd_smp_t   smp;
  aipd_meas_t  meas;
  logic        aux;
  logic        comm;
  logic [15:0] filt;
  logic [7:0]  act;
  logic [7:0]  led;
  logic        mled;
  logic [7:0]  rdv;
  logic        erv;
  logic [31:0] seed;
  logic [31:0] stamp;
  int          n_errors;
  int          comparisons;
  int          cycles;
  int          supm;
  int          fnm[8];
  int          rng[8];
  int          ft[4] = '{'h30, 'h31, 'h40, 'h41};

  aipd_top dut (
    .CORE_CLK(clk), .RESETN(rst_n), .CLK_EN(en), .REQ(req), .RSP(rsp), .SAMPLE(smp), .MEAS(meas),
    .AUX_MISSING(aux), .INT_COMM_ERR(comm), .FILTER_SEL(filt), .CH_ACTIVE(act), .CH_ERR_LED(led),
    .MOD_ERR_LED(mled));
  aipd_host host (.clk(clk), .req(req), .rsp(rsp));

  // 20 MHz clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // model: parameter fault of one channel (bad function byte or filter code 11)
  function automatic int perr(int c);
    return int'(!(fnm[c] inside {'h30, 'h31, 'h40, 'h41, 'hFF}) || ((supm >> (2 * c)) & 3) == 3);
  endfunction

  // model: expected diagnostic byte b of the record
  function automatic logic [7:0] ed(int b);
    int s = 0;
    int r = 0;
    int p = 0;
    int g;
    for (int i = 0; i < 8; i++) begin
      s |= int'((perr(i) | rng[i]) != 0) << i;
      r |= rng[i];
      p |= perr(i);
    end
    g = int'(s != 0) << 3 | int'(r != 0) << 2 | p << 7 | int'(comm) << 1 | int'(aux) << 4;
    g |= int'(g != 0);
    case (b)
      0: return 8'(g);
      1: return 8'h15;
      3: return {3'h0, comm, 4'h0};
      4: return 8'h71;
      5, 6: return 8'h08;
      7: return 8'(s);
      default: return b >= 8 ? 8'(perr(b - 8) | rng[b - 8]) : 8'h00;
    endcase
  endfunction

  task automatic rd(input logic [1:0] p, input int s, input int x, input logic [8:0] e);
    host.xfer(1'b0, p, 16'(s), 5'(x), 8'h00, rdv, erv);
    chk(40'({erv, rdv}), 40'(e));
  endtask

  task automatic wr(input logic [1:0] p, input int s, input int x, input int d, input logic e);
    host.xfer(1'b1, p, 16'(s), 5'(x), 8'(d), rdv, erv);
    chk(40'(erv), 40'(e));
  endtask

  // whole diagnostic record except the stamp
  task automatic dump();
    for (int i = 0; i < 16; i++) rd(PATH_REC, 'h01, i, {1'b0, ed(i)});
  endtask

  // filter select, active mask and indicators after the one-cycle status lag
  task automatic pins();
    logic [7:0] g;
    logic [7:0] a;
    @(posedge clk);
    #2 g = ed(0);
    for (int i = 0; i < 8; i++) a[i] = fnm[i] != 'hFF;
    chk(40'({filt, act, mled, led}), 40'({16'(supm), a, g[0], ed(7)}));
  endtask

  // one converter sample against the scaling model
  task automatic sm(input int ch, input int cur);
    int f;
    int o;
    int hi;
    int lo;
    int v;
    int fl;
    f = fnm[ch];
    o = (f == 'h30 || f == 'h40) ? 4000 : 0;
    hi = f < 'h40 ? 32511 : 20480;
    lo = f < 'h40 ? -4864 : -3277;
    v = (cur - o) * (f < 'h40 ? 27648 : 16384) / (o != 0 ? 16000 : 20000);
    fl = v > hi ? 'h80 : v < lo ? 'h40 : 0;
    v = v > hi ? hi : v < lo ? lo : v;
    smp = {1'b1, 3'(ch), 16'(cur)};
    @(posedge clk);
    #2 smp = {1'b0, ~smp.ch, ~smp.cur_ua};
    chk(40'({meas.valid, meas.ch, meas.value}), 40'({1'b1, 3'(ch), 16'(v)}));
    rng[ch] = fl;
    pins();
  endtask

  initial begin
    rst_n = 1'b0;
    en = 1'b1;
    smp = '0;
    aux = 1'b0;
    comm = 1'b0;
    seed = 32'h5B611CC3;
    supm = 0;
    for (int i = 0; i < 8; i++) fnm[i] = 'h31;
    for (int i = 0; i < 8; i++) rng[i] = 0;
    repeat (10) @(posedge clk);
    #2 rst_n = 1'b1;
    // reset values and record maps
    pins(); // reset pins
    for (int c = 0; c < 8; c++) rd(PATH_REC, 'h80 + c, 0, 9'h031); // default
    rd(PATH_IDX, 'h3100, 0, 9'h000); // low byte
    rd(PATH_IDX, 'h3101, 0, 9'h000); // high byte
    dump(); // constants
    for (int b = 0; b < 4; b++) rd(PATH_REC, 'h00, b, {1'b0, ed(b)}); // short record
    for (int b = 0; b < 4; b++) rd(PATH_IDX, 'h2F00, b, {1'b0, ed(b)}); // short index
    rd(PATH_REC, 'h00, 4, 9'h100); // beyond short record
    rd(PATH_IDX, 'h2F01, 6, 9'h008); // full index
    for (int b = 0; b < 16; b++) rd(PATH_SUBD, 2 + b, 0, {1'b0, ed(b)}); // order
    rd(PATH_SUBD, 'h12, 0, 9'h100); // gap
    wr(PATH_REC, 'h00, 0, 'h5A, 1'b1); // read-only
    $display("test reset values done");
    // parameters through all three paths
    wr(PATH_REC, 'h01, 0, 'h96, 1'b0);
    wr(PATH_REC, 'h01, 1, 'hC0, 1'b0);
    wr(PATH_IDX, 'h3103, 0, 'h55, 1'b0); // bad byte
    wr(PATH_SUBP, 'h04, 0, 'h40, 1'b0);
    supm = 'hC096;
    fnm[1] = 'h55;
    fnm[2] = 'h40;
    pins(); // filter codes
    rd(PATH_SUBP, 'h01, 1, 9'h0C0);
    rd(PATH_IDX, 'h3100, 0, 9'h096);
    rd(PATH_REC, 'h82, 0, 9'h040);
    rd(PATH_IDX, 'h3103, 0, 9'h055);
    dump(); // fault flags
    wr(PATH_REC, 'h81, 0, 'h31, 1'b0);
    wr(PATH_IDX, 'h3101, 0, 'h00, 1'b0);
    supm = 'h0096;
    fnm[1] = 'h31;
    pins(); // cleared
    $display("test parameters done");
    // supply and communication pins
    aux = 1'b1;
    comm = 1'b1;
    repeat (4) @(posedge clk);
    #2 pins();
    rd(PATH_REC, 'h01, 0, {1'b0, ed(0)});
    rd(PATH_REC, 'h01, 3, {1'b0, ed(3)});
    aux = 1'b0;
    comm = 1'b0;
    repeat (4) @(posedge clk);
    #2 pins();
    $display("test status pins done");
    // scaling in all four ranges, edges first then random
    for (int c = 0; c < 8; c++) begin
      fnm[c] = ft[c % 4];
      wr(PATH_REC, 'h80 + c, 0, ft[c % 4], 1'b0);
    end
    sm(1, 25000); // overflow
    sm(0, 0); // underflow
    sm(3, 27000); // overflow
    sm(2, 500); // underflow
    sm(5, 20000); // full scale
    repeat (40) sm(int'(xs() % 8), int'(xs() % 33000) - 6000);
    dump(); // range bits
    for (int b = 0; b < 4; b++) begin
      host.xfer(1'b0, PATH_REC, 16'h0001, 5'(16 + b), 8'h00, rdv, erv);
      stamp[8 * b +: 8] = rdv;
      rd(PATH_SUBD, 'h13, b, {1'b0, rdv}); // same stamp
    end
    chk(40'(stamp != 0), 40'(1)); // ticker ran
    $display("test scaling done");
    // switching a channel off
    wr(PATH_REC, 'h80, 0, 'hFF, 1'b0);
    fnm[0] = 'hFF;
    rng[0] = 0;
    pins();
    smp = {1'b1, 3'h0, 16'h1000};
    @(posedge clk);
    #2 smp = '0;
    chk(40'(meas.valid), 40'(0)); // dropped
    dump();
    $display("test channel off done");
    // enable low: every register holds, outputs unchanged afterwards
    en = 1'b0;
    repeat (6) @(posedge clk);
    #2 en = 1'b1;
    pins(); // held
    $display("test enable hold done");
    stop_test();
  end
endmodule
